/* sdt_startup.sv */
`include "sdt_defines.svh"
`timescale 1ns/1ps
`default_nettype none

module sdt_startup #(
    parameter int FLASH_CS_CYC = `SDT_FLASH_CS_MS * `SDT_CLK_KHZ,
    parameter int HOST_ACCESS_CYC = `SDT_HOST_ACCESS_MS_X10 * `SDT_CLK_KHZ / 10,
    parameter int FIRST_FRAME_CYC = `SDT_FIRST_FRAME_MS * `SDT_CLK_KHZ,
    parameter int OVERLAY_CYC = `SDT_OVERLAY_MS * `SDT_CLK_KHZ,
    parameter int AE_SETTLE_CYC = `SDT_AE_SETTLE_MS * `SDT_CLK_KHZ,
    parameter int PATCH_LOAD_CYC = `SDT_PATCH_LOAD_MS * `SDT_CLK_KHZ,
    parameter int RESUME_CYC = `SDT_RESUME_MS * `SDT_CLK_KHZ,
    parameter int H_ACTIVE = 720,
    parameter int H_TOTAL = 858,
    parameter int V_ACTIVE_NTSC = 480,
    parameter int V_TOTAL_NTSC = 525,
    parameter int V_ACTIVE_PAL = 576,
    parameter int V_TOTAL_PAL = 625
) (
    input wire logic REF_CLK_I,
    input wire logic RST_N_I,
    input wire logic VIDEO_STANDARD_STRAP_I,
    input wire logic FRAME_STROBE_I,
    input wire logic LINE_STROBE_I,
    input wire logic FRAME_RESTART_I,
    input wire logic PIX_CLK_INVERT_I,
    input wire logic [2:0] PIX_CLK_DRIVE_I,
    input wire logic [2:0] DATA_DRIVE_I,
    input wire logic HOST_PATCH_DONE_I,
    input wire logic OVERLAY_ENABLE_I,
    input wire logic [7:0] PIXEL_I,
    output logic PIX_CLK_O,
    output logic [7:0] PIX_DATA_O,
    output logic PIX_DATA_OE_O,
    output logic FRAME_STROBE_O,
    output logic LINE_STROBE_O,
    output logic STROBE_OE_O,
    output logic FLASH_CS_N_O,
    output logic HOST_ACCESS_OK_O,
    output logic PATCH_DONE_O,
    output logic OVERLAY_ON_O,
    output logic AE_SETTLED_O,
    output logic PAL_MODE_O,
    output logic [2:0] PIX_CLK_DRIVE_O,
    output logic [2:0] DATA_DRIVE_O
);

    localparam logic [24:0] FLASH_CS = 25'(FLASH_CS_CYC);
    localparam logic [24:0] HOST_ACCESS = 25'(HOST_ACCESS_CYC);
    localparam logic [24:0] FIRST_FRAME = 25'(FIRST_FRAME_CYC);
    localparam logic [24:0] OVERLAY = 25'(OVERLAY_CYC);
    localparam logic [24:0] AE_SETTLE = 25'(AE_SETTLE_CYC);
    localparam logic [24:0] PATCH_END = 25'(FLASH_CS_CYC + PATCH_LOAD_CYC);
    localparam logic [24:0] STRAP_HOLD = 25'(`SDT_STRAP_HOLD_CYC);
    localparam logic [17:0] RESUME = 18'(RESUME_CYC);
    localparam logic [9:0] H_ACT = 10'(H_ACTIVE);
    localparam logic [9:0] H_LAST = 10'(H_TOTAL - 1);
    localparam logic [9:0] VA_NTSC = 10'(V_ACTIVE_NTSC);
    localparam logic [9:0] VL_NTSC = 10'(V_TOTAL_NTSC - 1);
    localparam logic [9:0] VA_PAL = 10'(V_ACTIVE_PAL);
    localparam logic [9:0] VL_PAL = 10'(V_TOTAL_PAL - 1);

    if (FLASH_CS_CYC + PATCH_LOAD_CYC > 33554431 || AE_SETTLE_CYC > 33554431
        || FIRST_FRAME_CYC > 33554431 || OVERLAY_CYC > 33554431
        || RESUME_CYC > 262143 || RESUME_CYC < 1 || FLASH_CS_CYC < 1
        || H_TOTAL > 1024 || V_TOTAL_PAL > 1024 || V_TOTAL_NTSC > 1024
        || H_ACTIVE >= H_TOTAL || V_ACTIVE_NTSC >= V_TOTAL_NTSC
        || V_ACTIVE_PAL >= V_TOTAL_PAL) begin : g_check
        $error("sdt_startup: parameter out of range");
    end

    sdt_pkg::sdt_regs_type r;
    sdt_pkg::sdt_regs_type next_r;

    logic restart_rise;
    logic [9:0] v_act;
    logic [9:0] v_last;
    logic launch;

    always_comb begin
        next_r = r;
        restart_rise = r.sync_rst[1] & ~r.restart_prev;
        v_act = r.pins.pal ? VA_PAL : VA_NTSC;
        v_last = r.pins.pal ? VL_PAL : VL_NTSC;

        // two-flop synchronisers for the strobe, standard and restart pin inputs
        next_r.sync_fs = {r.sync_fs[0], FRAME_STROBE_I};
        next_r.sync_ls = {r.sync_ls[0], LINE_STROBE_I};
        next_r.sync_std = {r.sync_std[0], VIDEO_STANDARD_STRAP_I};
        next_r.sync_rst = {r.sync_rst[0], FRAME_RESTART_I};
        next_r.restart_prev = r.sync_rst[1];

        if (r.elapsed != `SDT_ELAPSED_MAX) begin
            next_r.elapsed = r.elapsed + 25'h000_0001;
        end

        next_r.pins.pix_drive = PIX_CLK_DRIVE_I;
        next_r.pins.data_drive = DATA_DRIVE_I;

        next_r.phase = ~r.phase;
        next_r.pins.pix_clk = (~r.phase) ^ PIX_CLK_INVERT_I;
        // launch where the default-polarity clock falls
        launch = r.phase;

        if (r.elapsed >= HOST_ACCESS) begin
            next_r.pins.host_access_ok = 1'b1;
        end
        next_r.pins.overlay_on = OVERLAY_ENABLE_I && (r.elapsed >= OVERLAY);
        if (r.elapsed >= AE_SETTLE) begin
            next_r.pins.ae_settled = 1'b1;
        end

        unique case (r.state)
            sdt_pkg::ST_STRAP: begin
                if (!r.sampled && r.elapsed == `SDT_STRAP_SAMPLE_CYC) begin
                    next_r.sampled = 1'b1;
                    next_r.pins.pal = r.sync_std[1];
                    next_r.mode = sdt_pkg::sdt_mode_type'({r.sync_fs[1], r.sync_ls[1]});
                end
                if (r.sampled && r.elapsed >= STRAP_HOLD) begin
                    next_r.pins.strobe_oe = 1'b1;
                    next_r.pins.data_oe = 1'b1;
                    next_r.state = sdt_pkg::ST_LOAD;
                end
            end
            sdt_pkg::ST_LOAD: begin
                // patch load by flash or host; auto and spare modes finish at once
                unique case (r.mode)
                    sdt_pkg::MODE_FLASH: begin
                        if (r.elapsed >= PATCH_END) begin
                            next_r.pins.flash_cs_n = 1'b1;
                            next_r.pins.patch_done = 1'b1;
                        end else if (r.elapsed >= FLASH_CS) begin
                            next_r.pins.flash_cs_n = 1'b0;
                        end
                    end
                    sdt_pkg::MODE_HOST: begin
                        if (HOST_PATCH_DONE_I && r.pins.host_access_ok) begin
                            next_r.pins.patch_done = 1'b1;
                        end
                    end
                    default: begin
                        next_r.pins.patch_done = 1'b1;
                    end
                endcase
                if (r.pins.patch_done) begin
                    next_r.state = sdt_pkg::ST_WAIT_FRAME;
                end
            end
            sdt_pkg::ST_WAIT_FRAME: begin
                if (r.elapsed >= FIRST_FRAME && launch) begin
                    next_r.state = sdt_pkg::ST_RUN;
                    next_r.hcnt = 10'h000;
                    next_r.vcnt = 10'h000;
                end
            end
            sdt_pkg::ST_RUN: begin
                if (restart_rise) begin
                    next_r.state = sdt_pkg::ST_RESTART;
                    next_r.restart_cnt = 18'h0_0000;
                end else if (launch) begin
                    // strobes and data change on launch edge
                    next_r.pins.frame_strobe = (r.vcnt < v_act);
                    next_r.pins.line_strobe = (r.vcnt < v_act) && (r.hcnt < H_ACT);
                    next_r.pins.data = PIXEL_I;
                    if (r.hcnt == H_LAST) begin
                        next_r.hcnt = 10'h000;
                        next_r.vcnt = (r.vcnt >= v_last) ? 10'h000 : r.vcnt + 10'h001;
                    end else begin
                        next_r.hcnt = r.hcnt + 10'h001;
                    end
                end
            end
            sdt_pkg::ST_RESTART: begin
                if (r.restart_cnt != `SDT_RESTART_MAX) begin
                    next_r.restart_cnt = r.restart_cnt + 18'h0_0001;
                end
                // strobes drop on a launch edge only
                if (launch) begin
                    next_r.pins.frame_strobe = 1'b0;
                    next_r.pins.line_strobe = 1'b0;
                end
                if (!r.sync_rst[1] && launch
                    && (r.mode != sdt_pkg::MODE_AUTO || r.restart_cnt >= RESUME)) begin
                    next_r.state = sdt_pkg::ST_RUN;
                    next_r.hcnt = 10'h000;
                    next_r.vcnt = 10'h000;
                end
            end
        endcase
    end

    always_ff @(posedge REF_CLK_I) begin
        if (!RST_N_I) begin
            r <= '0;
            r.state <= sdt_pkg::ST_STRAP;
            r.mode <= sdt_pkg::MODE_AUTO;
            r.pins.flash_cs_n <= 1'b1;
            r.pins.pix_drive <= `SDT_DRIVE_DEFAULT;
            r.pins.data_drive <= `SDT_DRIVE_DEFAULT;
        end else begin
            r <= next_r;
        end
    end

    assign PIX_CLK_O = r.pins.pix_clk;
    assign PIX_DATA_O = r.pins.data;
    assign PIX_DATA_OE_O = r.pins.data_oe;
    assign FRAME_STROBE_O = r.pins.frame_strobe;
    assign LINE_STROBE_O = r.pins.line_strobe;
    assign STROBE_OE_O = r.pins.strobe_oe;
    assign FLASH_CS_N_O = r.pins.flash_cs_n;
    assign HOST_ACCESS_OK_O = r.pins.host_access_ok;
    assign PATCH_DONE_O = r.pins.patch_done;
    assign OVERLAY_ON_O = r.pins.overlay_on;
    assign AE_SETTLED_O = r.pins.ae_settled;
    assign PAL_MODE_O = r.pins.pal;
    assign PIX_CLK_DRIVE_O = r.pins.pix_drive;
    assign DATA_DRIVE_O = r.pins.data_drive;

endmodule : sdt_startup

`default_nettype wire

/* sdt_defines.svh */
`ifndef SDT_DEFINES_SVH
`define SDT_DEFINES_SVH

`define SDT_CLK_KHZ 50000
`define SDT_STRAP_HOLD_US 50
`define SDT_STRAP_HOLD_CYC (`SDT_STRAP_HOLD_US * `SDT_CLK_KHZ / 1000)
`define SDT_STRAP_SAMPLE_CYC 25'h000_0010
`define SDT_FLASH_CS_MS 18
`define SDT_HOST_ACCESS_MS_X10 18
`define SDT_FIRST_FRAME_MS 235
`define SDT_OVERLAY_MS 235
`define SDT_AE_SETTLE_MS 400
`define SDT_PATCH_LOAD_MS 400
`define SDT_RESUME_MS 4
`define SDT_ELAPSED_MAX 25'h1FF_FFFF
`define SDT_RESTART_MAX 18'h3_FFFF
`define SDT_DRIVE_DEFAULT 3'h0

`endif

/* sdt_pkg.sv */
package sdt_pkg;

    typedef enum logic [2:0] {
        ST_STRAP,
        ST_LOAD,
        ST_WAIT_FRAME,
        ST_RUN,
        ST_RESTART
    } sdt_state_type;

    // decoded from the two strobe straps {frame, line}
    typedef enum logic [1:0] {
        MODE_AUTO = 2'h0,
        MODE_HOST = 2'h1,
        MODE_FLASH = 2'h2,
        MODE_SPARE = 2'h3
    } sdt_mode_type;

    typedef struct packed {
        logic pix_clk;
        logic frame_strobe;
        logic line_strobe;
        logic strobe_oe;
        logic [7:0] data;
        logic data_oe;
        logic flash_cs_n;
        logic host_access_ok;
        logic patch_done;
        logic overlay_on;
        logic ae_settled;
        logic pal;
        logic [2:0] pix_drive;
        logic [2:0] data_drive;
    } sdt_pins_type;

    typedef struct packed {
        sdt_state_type state;
        logic [24:0] elapsed;
        logic [17:0] restart_cnt;
        logic [1:0] sync_fs;
        logic [1:0] sync_ls;
        logic [1:0] sync_std;
        logic [1:0] sync_rst;
        logic restart_prev;
        logic sampled;
        sdt_mode_type mode;
        logic phase;
        logic [9:0] hcnt;
        logic [9:0] vcnt;
        sdt_pins_type pins;
    } sdt_regs_type;

endpackage : sdt_pkg

/* sdt_startup_properties.sv */
`timescale 1ns/1ps
`default_nettype none
module sdt_startup_chk #(
    parameter int FLASH_CS_CYC = 200,
    parameter int HOST_ACCESS_CYC = 100,
    parameter int FIRST_FRAME_CYC = 3000,
    parameter int OVERLAY_CYC = 3000,
    parameter int AE_SETTLE_CYC = 4000
) (
    input wire logic REF_CLK_I,
    input wire logic RST_N_I,
    input wire logic FRAME_RESTART_I,
    input wire logic PIX_CLK_INVERT_I,
    input wire logic [2:0] PIX_CLK_DRIVE_I,
    input wire logic PIX_CLK_O,
    input wire logic FRAME_STROBE_O,
    input wire logic LINE_STROBE_O,
    input wire logic FLASH_CS_N_O,
    input wire logic HOST_ACCESS_OK_O,
    input wire logic PATCH_DONE_O,
    input wire logic OVERLAY_ON_O,
    input wire logic AE_SETTLED_O,
    input wire logic PAL_MODE_O,
    input wire logic [2:0] PIX_CLK_DRIVE_O
);
    // cycles since reset release, saturating
    logic [24:0] cnt;
    always_ff @(posedge REF_CLK_I) begin
        if (!RST_N_I) cnt <= 25'h000_0000;
        else if (cnt != 25'h1FF_FFFF) cnt <= cnt + 25'h000_0001;
    end
    default clocking cb @(posedge REF_CLK_I); endclocking
    default disable iff (!RST_N_I);
    sequence s_restart_hit; $rose(FRAME_RESTART_I) && FRAME_STROBE_O; endsequence
    sequence s_quiet; !FRAME_STROBE_O && !LINE_STROBE_O; endsequence
    property p_launch;
        $changed(LINE_STROBE_O) && $stable(PIX_CLK_INVERT_I) |-> PIX_CLK_O == PIX_CLK_INVERT_I;
    endproperty
    property p_drive; $past(RST_N_I) |-> PIX_CLK_DRIVE_O == $past(PIX_CLK_DRIVE_I); endproperty
    property p_pal_hold; cnt > 25'h000_0014 && $past(RST_N_I) |-> $stable(PAL_MODE_O); endproperty
    property p_cs; cnt < FLASH_CS_CYC |-> FLASH_CS_N_O; endproperty
    property p_host; cnt < HOST_ACCESS_CYC |-> !HOST_ACCESS_OK_O; endproperty
    property p_frame; cnt < FIRST_FRAME_CYC |-> !FRAME_STROBE_O && !LINE_STROBE_O; endproperty
    property p_ovl; cnt < OVERLAY_CYC |-> !OVERLAY_ON_O; endproperty
    property p_ae; cnt < AE_SETTLE_CYC |-> !AE_SETTLED_O; endproperty
    property p_reset;
        disable iff (1'h0) !RST_N_I |=> FLASH_CS_N_O && !PATCH_DONE_O && PIX_CLK_DRIVE_O == 3'h0;
    endproperty
    property p_restart; s_restart_hit |-> ##[1:8] s_quiet [*8]; endproperty
    a_launch: assert property (p_launch) else $error("strobe moved off launch edge");
    a_drive: assert property (p_drive) else $error("drive code not passed on");
    a_pal_hold: assert property (p_pal_hold) else $error("standard changed after latch");
    a_cs: assert property (p_cs) else $error("flash select too early");
    a_host: assert property (p_host) else $error("host access too early");
    a_frame: assert property (p_frame) else $error("strobe too early");
    a_ovl: assert property (p_ovl) else $error("overlay too early");
    a_ae: assert property (p_ae) else $error("settled too early");
    a_reset: assert property (p_reset) else $error("reset values wrong");
    a_restart: assert property (p_restart) else $error("strobes kept after restart");
endmodule : sdt_startup_chk
bind sdt_startup sdt_startup_chk #(.FLASH_CS_CYC(FLASH_CS_CYC), .HOST_ACCESS_CYC(HOST_ACCESS_CYC),
    .FIRST_FRAME_CYC(FIRST_FRAME_CYC), .OVERLAY_CYC(OVERLAY_CYC), .AE_SETTLE_CYC(AE_SETTLE_CYC))
    chk (.REF_CLK_I, .RST_N_I, .FRAME_RESTART_I, .PIX_CLK_INVERT_I, .PIX_CLK_DRIVE_I, .PIX_CLK_O,
    .FRAME_STROBE_O, .LINE_STROBE_O, .FLASH_CS_N_O, .HOST_ACCESS_OK_O, .PATCH_DONE_O,
    .OVERLAY_ON_O, .AE_SETTLED_O, .PAL_MODE_O, .PIX_CLK_DRIVE_O);
`default_nettype wire

/* sdt_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
module sdt_host_model (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic [2:0] cfg_i,
    input wire logic access_ok_i,
    output logic fs_o,
    output logic ls_o,
    output logic std_o,
    output logic done_o
);
    int cnt = 0;
    always_ff @(posedge clk_i) begin
        cnt <= rst_n_i ? cnt + 1 : 0;
        // patch load only once access is allowed
        done_o <= rst_n_i && access_ok_i && cnt > 150;
    end
    // straps held past the hold window, then the pins show other levels
    assign {fs_o, ls_o, std_o} = (cnt < 2600) ? cfg_i : ~cfg_i;
endmodule : sdt_host_model
`default_nettype wire

/* startup_reset_output_timing_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module startup_reset_output_timing_tb_top;
    localparam int FS = 0, LS = 1, CS = 2, HOK = 3, PD = 4, AE = 5;
    localparam int P_FLASH = 2600, P_HOST = 100, P_FRAME = 3000, P_AE = 4000;
    localparam int P_PATCH = 300, P_RESUME = 50;
    logic [7:0] pix = 8'h5A;
    logic clk = 1'h0, rst_n = 1'h0, restart = 1'h0, inv = 1'h0, ovl_en = 1'h1;
    logic [2:0] pdrv = 3'h0, ddrv = 3'h0, cfg = 3'h0, pdo, ddo;
    logic fs, ls, std, hdone, pclk, pdoe, fso, lso, soe, cs_n, hok, pdone, ovl, ae, pal;
    logic [7:0] pdata;
    int fails = 0, compares = 0, n = 0;
    always #10 clk = ~clk;
    sdt_host_model host (.clk_i(clk), .rst_n_i(rst_n), .cfg_i(cfg), .access_ok_i(hok),
        .fs_o(fs), .ls_o(ls), .std_o(std), .done_o(hdone));
    sdt_startup #(.FLASH_CS_CYC(P_FLASH), .HOST_ACCESS_CYC(P_HOST), .FIRST_FRAME_CYC(P_FRAME),
        .OVERLAY_CYC(P_FRAME), .AE_SETTLE_CYC(P_AE), .PATCH_LOAD_CYC(P_PATCH),
        .RESUME_CYC(P_RESUME)) uut (.REF_CLK_I(clk), .RST_N_I(rst_n), .VIDEO_STANDARD_STRAP_I(std),
        .FRAME_STROBE_I(fs), .LINE_STROBE_I(ls), .FRAME_RESTART_I(restart),
        .PIX_CLK_INVERT_I(inv), .PIX_CLK_DRIVE_I(pdrv), .DATA_DRIVE_I(ddrv),
        .HOST_PATCH_DONE_I(hdone), .OVERLAY_ENABLE_I(ovl_en), .PIXEL_I(pix),
        .PIX_CLK_O(pclk), .PIX_DATA_O(pdata), .PIX_DATA_OE_O(pdoe), .FRAME_STROBE_O(fso),
        .LINE_STROBE_O(lso), .STROBE_OE_O(soe), .FLASH_CS_N_O(cs_n), .HOST_ACCESS_OK_O(hok),
        .PATCH_DONE_O(pdone), .OVERLAY_ON_O(ovl), .AE_SETTLED_O(ae), .PAL_MODE_O(pal),
        .PIX_CLK_DRIVE_O(pdo), .DATA_DRIVE_O(ddo));
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp) begin
            fails++;
            $display("mismatch at %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic chk_ge(input int got, input int lim);
        chk(8'(got >= lim), 8'h01);
    endtask : chk_ge
    task automatic tick(input int k);
        repeat (k) begin
            @(posedge clk);
            #1;
            n++;
        end
    endtask : tick
    task automatic wt(input int i, input logic v);
        int k;
        logic [5:0] a;
        for (k = 0; k < 9000; k++) begin
            a = {ae, pdone, hok, cs_n, lso, fso};
            if (a[i] === v) break;
            tick(1);
        end
        chk(8'(a[i] === v), 8'h01);
    endtask : wt
    task automatic start(input logic [2:0] c);
        cfg = c;
        rst_n = 1'h0;
        tick(12);
        rst_n = 1'h1;
        n = 0;
    endtask : start
    task automatic t_auto;
        int k;
        start(3'h1);
        tick(30);
        chk(pal, 1'h1);
        wt(FS, 1'h1);
        chk_ge(n, P_FRAME);
        tick(4);
        chk(ovl, 1'h1);
        chk(pal, 1'h1);
        ovl_en = 1'h0;
        tick(2);
        chk(ovl, 1'h0);
        ovl_en = 1'h1;
        wt(AE, 1'h1);
        chk_ge(n, P_AE);
        wt(LS, 1'h0);
        wt(LS, 1'h1);
        chk(pclk, 1'h0);
        chk(pdata, 8'h5A);
        pix = 8'hC3;
        tick(1);
        chk(pclk, 1'h1);
        chk(pdata, 8'h5A);
        tick(1);
        chk(pdata, 8'hC3);
        inv = 1'h1;
        tick(3);
        wt(LS, 1'h0);
        wt(LS, 1'h1);
        chk(pclk, 1'h1);
        inv = 1'h0;
        wt(FS, 1'h1);
        restart = 1'h1;
        n = 0;
        tick(20);
        chk(fso, 1'h0);
        restart = 1'h0;
        wt(FS, 1'h1);
        chk_ge(n, P_RESUME);
        for (k = 0; k < 8; k++) begin
            pdrv = 3'(k);
            ddrv = 3'(7 - k);
            tick(2);
            chk(pdo, 8'(k));
            chk(ddo, 8'(7 - k));
        end
        chk(cs_n, 1'h1);
        $display("test auto done");
    endtask : t_auto
    task automatic t_flash;
        start(3'h4);
        tick(30);
        chk(pal, 1'h0);
        wt(CS, 1'h0);
        chk_ge(n, P_FLASH);
        wt(CS, 1'h1);
        chk_ge(n, P_FLASH + P_PATCH);
        tick(2);
        chk(pdone, 1'h1);
        $display("test flash done");
    endtask : t_flash
    task automatic t_host;
        start(3'h2);
        chk(pdone, 1'h0);
        chk(cs_n, 1'h1);
        wt(HOK, 1'h1);
        chk_ge(n, P_HOST);
        chk(soe, 1'h0);
        chk(pdoe, 1'h0);
        wt(PD, 1'h1);
        chk_ge(n, 150);
        chk(soe, 1'h1);
        chk(pdoe, 1'h1);
        chk(cs_n, 1'h1);
        $display("test host done");
    endtask : t_host
    task automatic end_sim;
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : end_sim
    initial begin
        t_auto();
        t_flash();
        t_host();
        end_sim();
    end
    initial begin
        #600000;
        fails++;
        end_sim();
    end
endmodule : startup_reset_output_timing_tb_top
`default_nettype wire
